// *** design/sip_top.v ***
// I2C slave register port with direct command triggers
module sip_top (
  input wire clk, // 40 MHz system clock
  input wire rst_n, // Asynchronous reset, active low
  input wire interface_select, // Strap, high selects this port
  input wire address_select_0, // Strap, address bit low
  input wire address_select_1, // Strap, address bit high
  input wire serial_clock_line_in, // Bus clock level
  input wire serial_data_line_in, // Bus data level
  output reg serial_data_line_out_ff, // Data drive value, always low
  output reg serial_data_line_oe_ff, // High while pulling data low
  output reg preset_pulse_ff, // One-cycle preset command pulse
  output reg calib_start_ff // One-cycle oscillator calibration start
);
`include "sip_consts.vh"
  localparam ST_IDLE = 5'b00001;
  localparam ST_ADDR = 5'b00010;
  localparam ST_WORD = 5'b00100;
  localparam ST_WDAT = 5'b01000;
  localparam ST_RDAT = 5'b10000;

  ////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  // Registers on srst_n leave reset together, on the second clock edge after rst_n rises
  reg rst_a_ff, rst_b_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  wire srst_n = rst_b_ff;

  // Straps share the bus synchronisers; they are static, so skew is harmless
  reg [4:0] s1_ff, s2_ff;
  reg scl_d_ff, sda_d_ff;
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      s1_ff <= 5'h1f;
      s2_ff <= 5'h1f;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      s1_ff <= {interface_select, address_select_1, address_select_0, serial_clock_line_in, serial_data_line_in};
      s2_ff <= s1_ff;
      scl_d_ff <= s2_ff[1];
      sda_d_ff <= s2_ff[0];
    end
  end
  wire enabled = s2_ff[4]; // RULE_01
  wire scl = s2_ff[1];
  wire sda = s2_ff[0];
  wire scl_rise = scl & ~scl_d_ff;
  wire scl_fall = ~scl & scl_d_ff;
  wire start_cond = scl & scl_d_ff & sda_d_ff & ~sda; // RULE_04
  wire stop_cond = scl & scl_d_ff & ~sda_d_ff & sda;

  ////////////////////////////////////////////////////////////////
  // Byte engine
  reg [4:0] state_ff, nxt_state;
  reg [3:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg [5:0] word_addr_ff;
  reg ack_phase_ff;
  reg ack_drive_ff;
  // bit_cnt_ff reaches 8 only during the acknowledge clock
  reg wr_en_ff;
  reg [5:0] wr_addr_ff;
  reg [7:0] wr_data_ff;
  wire [7:0] rd_data;

  function [5:0] inc6;
    input [5:0] a;
    begin
      inc6 = a + 6'h01; // RULE_17
    end
  endfunction

  wire [7:0] rx_byte = {shift_ff[6:0], sda};
  // Byte is a leading zero, the four-zero prefix, the straps, then direction
  // The forbidden 00 strap is not refused here; the system must avoid it
  function addr_hit;
    input [7:0] b;
    input a1;
    input a0;
    begin
      addr_hit = (b[7:3] == {1'b0, `SIP_ADDR_PREFIX}) && (b[2:1] == {a1, a0}); // RULE_02 RULE_16
    end
  endfunction

  wire addr_match = addr_hit(rx_byte, s2_ff[3], s2_ff[2]); // RULE_02 RULE_16
  wire byte_done = scl_rise && !ack_phase_ff && bit_cnt_ff == 4'd7;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_ADDR: if (byte_done) nxt_state = !addr_match ? ST_IDLE : (rx_byte[0] ? ST_RDAT : ST_WORD);
      ST_WORD: if (byte_done) nxt_state = ST_WDAT;
      ST_WDAT: nxt_state = ST_WDAT;
      ST_RDAT: if (scl_rise && ack_phase_ff && sda) nxt_state = ST_IDLE; // RULE_12
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'd0;
      shift_ff <= 8'h00;
      word_addr_ff <= 6'h00;
      ack_phase_ff <= 1'b0;
      ack_drive_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      wr_addr_ff <= 6'h00;
      wr_data_ff <= 8'h00;
      serial_data_line_out_ff <= 1'b0;
      serial_data_line_oe_ff <= 1'b0;
    end else begin
      wr_en_ff <= 1'b0;
      if (!enabled || stop_cond) begin
        state_ff <= ST_IDLE;
        ack_phase_ff <= 1'b0;
        serial_data_line_oe_ff <= 1'b0;
      end else if (start_cond) begin
        state_ff <= ST_ADDR; // RULE_16
        bit_cnt_ff <= 4'd0;
        ack_phase_ff <= 1'b0;
        serial_data_line_oe_ff <= 1'b0;
      end else begin
        state_ff <= nxt_state;
        if (scl_rise && !ack_phase_ff) begin
          shift_ff <= rx_byte;
          bit_cnt_ff <= bit_cnt_ff + 4'd1;
          if (bit_cnt_ff == 4'd7) begin
            ack_phase_ff <= 1'b1;
            bit_cnt_ff <= 4'd0;
            ack_drive_ff <= 1'b0;
            case (state_ff)
              ST_ADDR: ack_drive_ff <= addr_match;
              ST_WORD: begin
                word_addr_ff <= rx_byte[5:0];
                ack_drive_ff <= 1'b1;
              end
              ST_WDAT: begin
                wr_en_ff <= 1'b1; // RULE_05
                wr_addr_ff <= word_addr_ff;
                wr_data_ff <= rx_byte;
                word_addr_ff <= inc6(word_addr_ff); // RULE_05
                ack_drive_ff <= 1'b1;
              end
              ST_RDAT: word_addr_ff <= inc6(word_addr_ff); // RULE_10
              default: ack_drive_ff <= 1'b0;
            endcase
          end
        end
        if (scl_fall) begin
          if (ack_phase_ff && bit_cnt_ff == 4'd0) begin
            // Ninth clock: acknowledge, or leave the line to the master after a sent byte
            serial_data_line_oe_ff <= ack_drive_ff; // RULE_12 RULE_16
            ack_drive_ff <= 1'b0;
            bit_cnt_ff <= 4'd8;
          end else if (ack_phase_ff) begin
            ack_phase_ff <= 1'b0;
            bit_cnt_ff <= 4'd0;
            serial_data_line_oe_ff <= (state_ff == ST_RDAT) && !rd_data[7]; // RULE_09
            shift_ff <= {rd_data[6:0], 1'b0};
          end else if (state_ff == ST_RDAT) begin
            serial_data_line_oe_ff <= !shift_ff[7]; // RULE_10
            shift_ff <= {shift_ff[6:0], 1'b0};
          end
        end
        // Transmit byte must survive the receive shift on rising edges
        if (state_ff == ST_RDAT && scl_rise && !ack_phase_ff) begin
          shift_ff <= shift_ff;
          if (bit_cnt_ff == 4'd7) begin
            serial_data_line_out_ff <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Direct commands
  // Key must match exactly, so a stray register write cannot fire a command
  function cmd_hit;
    input [5:0] addr;
    input [5:0] target;
    input [7:0] data;
    begin
      cmd_hit = (addr == target) && (data == `SIP_CMD_KEY); // RULE_13
    end
  endfunction

  // Pulses only; the preset clear and calibration engine act on them
  always @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      preset_pulse_ff <= 1'b0;
      calib_start_ff <= 1'b0;
    end else begin
      preset_pulse_ff <= wr_en_ff && cmd_hit(wr_addr_ff, `SIP_REG_PRESET, wr_data_ff); // RULE_13 RULE_14
      calib_start_ff <= wr_en_ff && cmd_hit(wr_addr_ff, `SIP_REG_CALIB, wr_data_ff); // RULE_13 RULE_15
    end
  end

  // Command registers are write-only triggers, not stored
  wire store_en = wr_en_ff && wr_addr_ff != `SIP_REG_PRESET && wr_addr_ff != `SIP_REG_CALIB;

  sip_regfile u_regs (
    .clk(clk),
    .rst_n(srst_n),
    .clear(preset_pulse_ff),
    .wr_en(store_en),
    .wr_addr(wr_addr_ff),
    .wr_data(wr_data_ff),
    .rd_addr(word_addr_ff),
    .rd_data_ff(rd_data)
  );
endmodule

// *** design/sip_consts.vh ***
// Constants for the sensor I2C register port
// Summary of operation
// RULE_01 - Port works only while the interface select strap is high.
// RULE_02 - Device address is 0000, then address_select_1, address_select_0, then direction bit.
// RULE_03 - System must not strap both address select pins low.
// RULE_04 - A START is data falling while clock is high.
// RULE_05 - Write: address, word address, data bytes; each stored, address advances.
// RULE_06 - Master reads via repeated START or fresh START with read address.
// RULE_07 - Master sets pointer first with START, write address, word address.
// RULE_08 - Master issues repeated START right after the word address acknowledge.
// RULE_09 - After read address, slave sends byte at stored word address.
// RULE_10 - Slave sends any number of bytes, advancing word address each byte.
// RULE_11 - Random read: master not-acknowledges single byte, then STOP.
// RULE_12 - Sequential read ends with master not-acknowledge; slave then releases data.
// RULE_13 - Writing key 0x96 to a command register runs that direct command.
// RULE_14 - Preset command returns every register to its default.
// RULE_15 - Calibration command starts calibration of both RC oscillators.
// RULE_16 - Acknowledge only matching address; otherwise stay released until next START.
// RULE_17 - Word address counter is six bits and wraps after 0x3f.
`ifndef SIP_CONSTS_VH
`define SIP_CONSTS_VH
`define SIP_ADDR_PREFIX 4'h0
`define SIP_CMD_KEY 8'h96
`define SIP_REG_PRESET 6'h3c
`define SIP_REG_CALIB 6'h3d
`define SIP_REG_DEPTH 64
`define SIP_REG_RESET 8'h00
`endif

// *** design/sip_regfile.v ***
// Register memory of the sensor register port, registered read data
module sip_regfile (
  input wire clk, // System clock
  input wire rst_n, // Synchronised reset, active low
  input wire clear, // Return all words to default
  input wire wr_en, // Write strobe
  input wire [5:0] wr_addr, // Write word address
  input wire [7:0] wr_data, // Write data
  input wire [5:0] rd_addr, // Read word address
  output reg [7:0] rd_data_ff // Registered read data
);
`include "sip_consts.vh"
  reg [7:0] mem_ff [0:`SIP_REG_DEPTH-1];
  integer i;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `SIP_REG_DEPTH; i = i + 1) begin
        mem_ff[i] <= `SIP_REG_RESET;
      end
    end else if (clear) begin
      for (i = 0; i < `SIP_REG_DEPTH; i = i + 1) begin
        mem_ff[i] <= `SIP_REG_RESET; // RULE_14
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule

// *** verification/sip_properties.sv ***
// Pin-level checks for the sensor register port
module sip_properties (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic interface_select, // Port strap
  input wire logic serial_clock_line_in, // Bus clock
  input wire logic serial_data_line_out_ff, // Drive value
  input wire logic serial_data_line_oe_ff, // Drive enable
  input wire logic preset_pulse_ff, // Preset pulse
  input wire logic calib_start_ff // Calibration pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_drive_low: assert property (!serial_data_line_out_ff) else $error("drive not low");
  a_off_no_drive: assert property (!interface_select [*6] |-> !serial_data_line_oe_ff) else $error("drive off");
  a_off_no_cmd: assert property (!interface_select [*6] |-> !preset_pulse_ff && !calib_start_ff) else $error("cmd off");
  a_cmd_apart: assert property (!(preset_pulse_ff && calib_start_ff)) else $error("both cmds");
  a_preset_once: assert property (preset_pulse_ff |=> !preset_pulse_ff [*8]) else $error("preset long");
  a_calib_once: assert property (calib_start_ff |=> !calib_start_ff [*8]) else $error("calib long");
  a_idle_steady: assert property (serial_clock_line_in [*8] |-> $stable(serial_data_line_oe_ff)) else $error("oe moved");
  a_cmd_on: assert property (preset_pulse_ff || calib_start_ff |-> $past(interface_select, 4)) else $error("cmd sel");
endmodule
////////////////////////////////////////
bind sip_top sip_properties u_props (.clk(clk), .rst_n(rst_n), .interface_select(interface_select),
  .serial_clock_line_in(serial_clock_line_in), .serial_data_line_out_ff(serial_data_line_out_ff),
  .serial_data_line_oe_ff(serial_data_line_oe_ff), .preset_pulse_ff(preset_pulse_ff), .calib_start_ff(calib_start_ff));

// *** verification/sip_i2c_master.sv ***
// Bus master model, 200 ns bus clock, open-drain data
module sip_i2c_master (
  output logic scl, // Bus clock, idles high
  output logic sda_m, // Data drive, 1 releases
  input wire logic sda // Resolved data line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  // Long low phase first: slave may still hold its acknowledge
  task automatic start();
    sda_m = 1'h1;
    #100 scl = 1'h1;
    #50 sda_m = 1'h0;
    #50 scl = 1'h0;
    #50;
  endtask
  task automatic stop();
    sda_m = 1'h0;
    #50 scl = 1'h1;
    #50 sda_m = 1'h1;
    #100;
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_m = b;
    #50 scl = 1'h1;
    #50 s = sda;
    #50 scl = 1'h0;
    #50;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'h1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

// *** verification/test_sensor_i2c_register_port.sv ***
// Self-checking bench for the sensor register port
module test_sensor_i2c_register_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic sel = 1'h1;
  logic scl, sda_m, out, oe, preset, calib, a;
  logic [7:0] r;
  logic [6:0] dev = 7'h02; // Straps a1 high, a0 low, never both low
  logic [13:0] rows [4] = '{{6'h00, 8'ha5}, {6'h15, 8'h5a}, {6'h3f, 8'hc3}, {6'h3b, 8'h01}};
  int bad_count = 0;
  int check_count = 0;
  int n_cmd = 0;
  wire logic sda = sda_m & ~oe; // Pull-up unless pulled low
  sip_i2c_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
  sip_top dut (.clk(clk), .rst_n(rst_n), .interface_select(sel), .address_select_0(1'h0),
    .address_select_1(1'h1), .serial_clock_line_in(scl), .serial_data_line_in(sda),
    .serial_data_line_out_ff(out), .serial_data_line_oe_ff(oe), .preset_pulse_ff(preset), .calib_start_ff(calib));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_cmd += 16 * calib + preset;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] wa, input logic [7:0] d, input int n);
    m.start();
    m.wbyte({dev, 1'h0}, a);
    chk({7'h0, a}, 8'h01);
    m.wbyte({2'h0, wa}, a);
    for (int k = 0; k < n; k++) begin
      m.wbyte(d, a);
      d += 8'h11;
    end
    m.stop();
  endtask
  task automatic rd(input logic [5:0] wa, input logic [7:0] d, input int n, input logic ptr);
    if (ptr) begin
      m.start();
      m.wbyte({dev, 1'h0}, a);
      m.wbyte({2'h0, wa}, a);
    end
    m.start();
    m.wbyte({dev, 1'h1}, a);
    for (int k = 1; k <= n; k++) begin
      m.rbyte(k == n, r);
      chk(r, d);
      d += 8'h11;
    end
    m.stop();
  endtask
  task automatic probe(input logic [7:0] ad);
    m.start();
    m.wbyte(ad, a);
    m.stop();
    chk({7'h0, a}, 8'h00);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #400us;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    #2 rst_n = 1'h1;
    repeat (6) @(posedge clk);
    #2 chk({4'h0, out, oe, preset, calib}, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][13:8], rows[i][7:0], 1);
      rd(rows[i][13:8], rows[i][7:0], 1, 1'h1);
    end
    $display("rows done");
    wr(6'h3f, 8'h11, 3);
    rd(6'h3f, 8'h11, 2, 1'h1);
    rd(6'h00, 8'h33, 1, 1'h0);
    $display("wrap done");
    wr(6'h3c, 8'h95, 1);
    wr(6'h3d, 8'h96, 1);
    chk(8'(n_cmd), 8'h10);
    wr(6'h3c, 8'h96, 1);
    chk(8'(n_cmd), 8'h11);
    rd(6'h3f, 8'h00, 1, 1'h1);
    $display("commands done");
    wr(6'h15, 8'h77, 1);
    @(posedge clk);
    #2 rst_n = 1'h0;
    repeat (3) @(posedge clk);
    #2 rst_n = 1'h1;
    repeat (6) @(posedge clk);
    #2 chk({4'h0, out, oe, preset, calib}, 8'h00);
    rd(6'h15, 8'h00, 1, 1'h1);
    $display("reset done");
    probe({7'h03, 1'h0});
    @(posedge clk);
    #2 sel = 1'h0;
    probe({dev, 1'h0});
    $display("refusals done");
    stop_test();
  end
endmodule
